// file: common/ebsl_regs.svh
// error bank status logger: register selects, field positions, resets
// assumes: included by the package and by every design file that needs it
//
// How it works
// (RULE1) arch error code sits in bits 15:0
// (RULE2) implementation error code sits in bits 31:16
// (RULE3) bits 52:32 carry implementation extra info
// (RULE4) capability bit decides meaning of bits 56:53
// (RULE5) threshold field meaningless when not corrected
// (RULE6) threshold codes: untracked, below, above, reserved
// (RULE7) bit 57 flags corrupted processor context
// (RULE8) bit 58 set only when location holds address
// (RULE9) bit 59 set only when extra info held
// (RULE10) bit 60 marks error enabled by control bit
// (RULE11) bit 61 marks error not corrected
// (RULE12) bit 62 overflow on collision, software clears
// (RULE13) enabled beats disabled, uncorrected beats corrected
// (RULE14) bit 63 valid set on log, software clears
// (RULE15) rank uncorrected, cautionary, normal; newer wins ties; the code keeps the older of two uncorrected
// (RULE16) winner supplies all fields; overflow always set
// (RULE17) tracked codes only for monitored corrected events
// (RULE18) absent location register faults every access
// (RULE19) location cleared by zeros, ones fault
// (RULE20) location kind chosen per error type
// (RULE21) status cleared by zeros, ones fault
// (RULE22) control bits enable reporting; unimplemented bits fixed
// (RULE23) cleared status means next error logs cleanly
`ifndef EBSL_REGS_SVH
`define EBSL_REGS_SVH

// ---------------------------------------------------------------
// register selects
// ---------------------------------------------------------------
`define EBSL_SEL_CONTROL 2'h0
`define EBSL_SEL_STATUS 2'h1
`define EBSL_SEL_LOCATION 2'h2
`define EBSL_SEL_EXTRA 2'h3

// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define EBSL_ARCH_LO 0
`define EBSL_ARCH_HI 15
`define EBSL_IMPL_LO 16
`define EBSL_IMPL_HI 31
`define EBSL_OTHER_LO 32
`define EBSL_OTHER_HI 52
`define EBSL_THR_LO 53
`define EBSL_THR_HI 54
`define EBSL_RSV_LO 55
`define EBSL_RSV_HI 56
`define EBSL_PCC_BIT 57
`define EBSL_LOCATION_GOOD_FLAG_BIT 58
`define EBSL_EXTRA_INFO_GOOD_FLAG_BIT 59
`define EBSL_EN_BIT 60
`define EBSL_UC_BIT 61
`define EBSL_OVER_BIT 62
`define EBSL_VAL_BIT 63

// ---------------------------------------------------------------
// threshold codes and reset values
// ---------------------------------------------------------------
`define EBSL_THR_NONE 2'h0
`define EBSL_THR_NORMAL 2'h1
`define EBSL_THR_CAUTION 2'h2
`define EBSL_RST_STATUS 64'h0000000000000000
`define EBSL_RST_CONTROL 64'h0000000000000000
`define EBSL_RST_LOCATION 64'h0000000000000000

`endif

// file: common/ebsl_pkg.sv
// error bank status logger: shared types
// assumes: the register header is on the include path
`default_nettype none
`include "ebsl_regs.svh"
package ebsl_pkg;
   // location kind of a logged address
   typedef enum logic [1:0] {
      EBSL_LOC_OFFSET = 2'h0,
      EBSL_LOC_LINEAR = 2'h1,
      EBSL_LOC_PHYS = 2'h2
   } ebsl_loc_e;

   // one detected error as posted by a hardware unit
   typedef struct packed {
      logic [15:0] arch_code;
      logic [15:0] impl_code;
      logic [20:0] other_info;
      logic [3:0] impl_hi;
      logic context_corrupt;
      logic has_location;
      logic has_extra;
      logic not_corrected;
      logic monitored;
      logic above_threshold;
      logic [5:0] enable_index;
      ebsl_loc_e loc_kind;
      logic [63:0] location;
   } ebsl_event_s;

   // access sequencer states
   typedef enum logic [2:0] {
      EBSL_IDLE = 3'b001,
      EBSL_DONE = 3'b010,
      EBSL_FAULT = 3'b100
   } ebsl_state_e;
endpackage
`default_nettype wire

// file: common/ebsl_bank_if.sv
// error bank status logger: bundle between decision logic and bank store
// assumes: one clock domain, written in the same cycle it is asserted
`timescale 1ns/1ps
`default_nettype none
interface ebsl_bank_if;
   logic wr_status;
   logic [63:0] status_d;
   logic wr_location;
   logic [63:0] location_d;
   logic [63:0] status_q;
   logic [63:0] location_q;

   modport writer (
      output wr_status,
      output status_d,
      output wr_location,
      output location_d,
      input status_q,
      input location_q
   );
   modport store (
      input wr_status,
      input status_d,
      input wr_location,
      input location_d,
      output status_q,
      output location_q
   );
endinterface
`default_nettype wire

// file: logic/ebsl_bank_store.sv
// error bank status logger: storage of status and location words
// assumes: writes arrive as single-cycle strobes from the decision logic
`timescale 1ns/1ps
`default_nettype none
`include "ebsl_regs.svh"
module ebsl_bank_store (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // bank bundle
   ebsl_bank_if.store bank
);
   import ebsl_pkg::*;

   typedef struct packed {
      logic [63:0] status;
      logic [63:0] location;
   } ebsl_store_s;

   ebsl_store_s st_q;
   ebsl_store_s st_d;

   // take each word on its strobe
   always_comb begin
      st_d = st_q;
      if (bank.wr_status) begin
         st_d.status = bank.status_d;
      end
      if (bank.wr_location) begin
         st_d.location = bank.location_d;
      end
   end

   // registered storage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q <= '{status: `EBSL_RST_STATUS, location: `EBSL_RST_LOCATION};
      end else begin
         st_q <= st_d;
      end
   end

   assign bank.status_q = st_q.status;
   assign bank.location_q = st_q.location;
endmodule
`default_nettype wire

// file: logic/ebsl_logger.sv
// error bank status logger: top, event logging and register access
// assumes: events are one-cycle strobes; access strobes are one cycle and
// the next access waits for ack
`timescale 1ns/1ps
`default_nettype none
`include "ebsl_regs.svh"
module ebsl_logger #(
   parameter bit LOCATION_PRESENT = 1'b1,
   parameter bit TES_PRESENT = 1'b1,
   parameter logic [63:0] CONTROL_IMPL_MASK = 64'hFFFFFFFFFFFFFFFF
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // error event from the hardware unit
   input wire logic event_valid,
   input wire ebsl_pkg::ebsl_event_s event_info,
   // extra info register state from outside this block
   input wire logic extra_info_present,
   // register access
   input wire logic acc_rd,
   input wire logic acc_wr,
   input wire logic [1:0] acc_sel,
   input wire logic [63:0] acc_wdata,
   output logic acc_ack,
   output logic acc_gp_fault,
   output logic [63:0] acc_rdata,
   // bank state seen by the unit
   output logic [63:0] error_bank_control,
   output logic bank_overflow
);
   import ebsl_pkg::*;

   typedef struct packed {
      ebsl_state_e state;
      logic [63:0] control;
      logic [63:0] rdata;
      logic fault;
      ebsl_loc_e loc_kind;
   } ebsl_top_s;

   ebsl_top_s s_q;
   ebsl_top_s s_d;
   ebsl_bank_if bank ();

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------

   // rank of a status word: 2 uncorrected, 1 cautionary, 0 normal
   function automatic logic [1:0] rank_of(input logic [63:0] w);
      if (w[`EBSL_UC_BIT]) begin
         rank_of = 2'h2;
      end else if (w[`EBSL_THR_HI:`EBSL_THR_LO] == `EBSL_THR_CAUTION) begin
         rank_of = 2'h1;
      end else begin
         rank_of = 2'h0;
      end
   endfunction

   // build a status word from an incoming event
   function automatic logic [63:0] build_status(input ebsl_event_s e,
         input logic enabled, input logic extra_ok);
      logic [63:0] w;
      w = 64'h0000000000000000;
      w[`EBSL_ARCH_HI:`EBSL_ARCH_LO] = e.arch_code; // see (RULE1)
      w[`EBSL_IMPL_HI:`EBSL_IMPL_LO] = e.impl_code; // see (RULE2)
      w[`EBSL_OTHER_HI:`EBSL_OTHER_LO] = e.other_info; // see (RULE3)
      if (!TES_PRESENT) begin
         w[`EBSL_RSV_HI:`EBSL_THR_LO] = e.impl_hi; // see (RULE4)
      end else if (e.not_corrected) begin
         w[`EBSL_THR_HI:`EBSL_THR_LO] = `EBSL_THR_NONE; // see (RULE5)
      end else if (e.monitored) begin
         // see (RULE6) see (RULE17)
         w[`EBSL_THR_HI:`EBSL_THR_LO] = e.above_threshold ?
            `EBSL_THR_CAUTION : `EBSL_THR_NORMAL;
      end else begin
         w[`EBSL_THR_HI:`EBSL_THR_LO] = `EBSL_THR_NONE; // see (RULE17)
      end
      w[`EBSL_PCC_BIT] = e.context_corrupt; // see (RULE7)
      // see (RULE8)
      w[`EBSL_LOCATION_GOOD_FLAG_BIT] = e.has_location && LOCATION_PRESENT;
      w[`EBSL_EXTRA_INFO_GOOD_FLAG_BIT] = e.has_extra && extra_ok; // see (RULE9)
      w[`EBSL_EN_BIT] = enabled; // see (RULE10)
      w[`EBSL_UC_BIT] = e.not_corrected; // see (RULE11)
      w[`EBSL_VAL_BIT] = 1'b1; // see (RULE14)
      build_status = w;
   endfunction

   // ---------------------------------------------------------------
   // event decision
   // ---------------------------------------------------------------
   logic ev_enabled;
   logic [63:0] ev_status;
   logic old_valid;
   logic new_wins;

   // see (RULE22)
   assign ev_enabled = s_q.control[event_info.enable_index];
   assign ev_status = build_status(event_info, ev_enabled, extra_info_present);
   // see (RULE23)
   assign old_valid = bank.status_q[`EBSL_VAL_BIT];

   // choose survivor of a collision
   always_comb begin
      new_wins = 1'b1;
      if (old_valid) begin
         if (bank.status_q[`EBSL_EN_BIT] != ev_enabled) begin
            new_wins = ev_enabled; // see (RULE13)
         end else if (bank.status_q[`EBSL_UC_BIT]) begin
            new_wins = 1'b0; // see (RULE13)
         end else if (rank_of(ev_status) < rank_of(bank.status_q)) begin
            new_wins = 1'b0; // see (RULE15)
         end else begin
            new_wins = 1'b1; // see (RULE15)
         end
      end
   end

   // ---------------------------------------------------------------
   // register access and bank writes
   // ---------------------------------------------------------------
   logic access;
   logic ones_fault;

   assign access = (acc_rd || acc_wr) && (s_q.state == EBSL_IDLE);

   // fault on any access to an absent register, and on status or location writes with ones
   always_comb begin
      ones_fault = 1'b0;
      case (acc_sel)
         `EBSL_SEL_CONTROL: begin
            ones_fault = 1'b0;
         end
         `EBSL_SEL_STATUS: begin
            ones_fault = acc_wr && (acc_wdata != 64'h0); // see (RULE21)
         end
         `EBSL_SEL_LOCATION: begin
            // see (RULE18) see (RULE19)
            ones_fault = !LOCATION_PRESENT || (acc_wr && (acc_wdata != 64'h0));
         end
         default: begin
            ones_fault = 1'b1;
         end
      endcase
   end

   // next state of control, sequencer and bank strobes
   always_comb begin
      s_d = s_q;
      bank.wr_status = 1'b0;
      bank.status_d = bank.status_q;
      bank.wr_location = 1'b0;
      bank.location_d = bank.location_q;
      // hardware logging; old winner keeps all its fields but overflow
      if (event_valid) begin
         bank.wr_status = 1'b1;
         if (new_wins) begin
            bank.status_d = ev_status; // see (RULE16)
            bank.status_d[`EBSL_OVER_BIT] = old_valid ||
               bank.status_q[`EBSL_OVER_BIT]; // see (RULE12)
            if (ev_status[`EBSL_LOCATION_GOOD_FLAG_BIT]) begin
               bank.wr_location = 1'b1;
               bank.location_d = event_info.location;
               s_d.loc_kind = event_info.loc_kind; // see (RULE20)
            end else begin
               bank.wr_location = LOCATION_PRESENT;
               bank.location_d = 64'h0;
            end
         end else begin
            bank.status_d[`EBSL_OVER_BIT] = 1'b1; // see (RULE16)
         end
      end
      case (s_q.state)
         EBSL_IDLE: begin
            if (access && ones_fault) begin
               s_d.state = EBSL_FAULT;
               s_d.fault = 1'b1;
               s_d.rdata = 64'h0;
            end else if (access) begin
               s_d.state = EBSL_DONE;
               s_d.fault = 1'b0;
               s_d.rdata = 64'h0;
               if (acc_rd) begin
                  case (acc_sel)
                     `EBSL_SEL_CONTROL: s_d.rdata = s_q.control;
                     `EBSL_SEL_STATUS: s_d.rdata = bank.status_q;
                     `EBSL_SEL_LOCATION: s_d.rdata = bank.location_q;
                     default: s_d.rdata = 64'h0;
                  endcase
               end else if (acc_sel == `EBSL_SEL_CONTROL) begin
                  // see (RULE22)
                  s_d.control = (acc_wdata & CONTROL_IMPL_MASK) |
                     (s_q.control & ~CONTROL_IMPL_MASK);
               end else if (!event_valid) begin
                  // zero write clears; a same-cycle event wins
                  if (acc_sel == `EBSL_SEL_STATUS) begin
                     bank.wr_status = 1'b1; // see (RULE21) see (RULE23)
                     bank.status_d = 64'h0;
                  end else begin
                     bank.wr_location = 1'b1; // see (RULE19)
                     bank.location_d = 64'h0;
                  end
               end
            end
         end
         EBSL_DONE: begin
            s_d.state = EBSL_IDLE;
         end
         EBSL_FAULT: begin
            s_d.state = EBSL_IDLE;
         end
         default: begin
            s_d.state = EBSL_IDLE;
         end
      endcase
   end

   // registered state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q <= '{state: EBSL_IDLE, control: `EBSL_RST_CONTROL,
                  rdata: 64'h0, fault: 1'b0, loc_kind: EBSL_LOC_OFFSET};
      end else begin
         s_q <= s_d;
      end
   end

   // bank storage
   ebsl_bank_store u_store (
      .clk(clk),
      .reset_n(reset_n),
      .bank(bank)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign acc_ack = (s_q.state == EBSL_DONE) || (s_q.state == EBSL_FAULT);
   assign acc_gp_fault = acc_ack && s_q.fault; // see (RULE18)
   assign acc_rdata = s_q.rdata;
   assign error_bank_control = s_q.control;
   assign bank_overflow = bank.status_q[`EBSL_OVER_BIT];
endmodule
`default_nettype wire

// file: dv/ebsl_logger_props.sv
// error bank status logger: checker on the top module's ports
// assumes: bound to ebsl_logger, one clock, reset_n synchronous low
`timescale 1ns/1ps
`default_nettype none
`include "ebsl_regs.svh"
module ebsl_chk #(
   parameter bit LOCATION_PRESENT = 1'b1,
   parameter logic [63:0] CONTROL_IMPL_MASK = 64'hFFFFFFFFFFFFFFFF
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // event side
   input wire logic event_valid,
   input wire ebsl_pkg::ebsl_event_s event_info,
   input wire logic extra_info_present,
   // register access
   input wire logic acc_rd,
   input wire logic acc_wr,
   input wire logic [1:0] acc_sel,
   input wire logic [63:0] acc_wdata,
   input wire logic acc_ack,
   input wire logic acc_gp_fault,
   input wire logic [63:0] acc_rdata,
   // bank state
   input wire logic [63:0] error_bank_control,
   input wire logic bank_overflow
);
   import ebsl_pkg::*;
   // requests taken by the idle sequencer, by target
   wire logic take = (acc_rd | acc_wr) & !acc_ack;
   wire logic t_ctl = take & (acc_sel == `EBSL_SEL_CONTROL);
   wire logic t_st = take & acc_wr & (acc_sel == `EBSL_SEL_STATUS);
   wire logic t_loc = take & (acc_sel == `EBSL_SEL_LOCATION);
   wire logic wzero = acc_wdata == 64'h0;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_st_ones;
      t_st && !wzero |=> acc_ack && acc_gp_fault;
   endproperty
   a_st_ones: assert property (p_st_ones)
      else $error("status ones taken");
   property p_st_zero;
      t_st && wzero |=> acc_ack && !acc_gp_fault;
   endproperty
   a_st_zero: assert property (p_st_zero)
      else $error("status clear faulted");
   property p_loc_wr;
      t_loc && acc_wr && !wzero |=> acc_ack && acc_gp_fault;
   endproperty
   a_loc_wr: assert property (p_loc_wr)
      else $error("location ones taken");
   property p_loc_rd;
      t_loc && acc_rd |=> acc_ack && (acc_gp_fault == !LOCATION_PRESENT);
   endproperty
   a_loc_rd: assert property (p_loc_rd)
      else $error("location read fault");
   property p_ovf_set;
      $rose(bank_overflow) |-> $past(event_valid);
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow w/o event");
   property p_ovf_clr;
      $fell(bank_overflow) |-> $past(t_st && wzero);
   endproperty
   a_ovf_clr: assert property (p_ovf_clr)
      else $error("overflow self clear");
   property p_ctl_wr;
      t_ctl && acc_wr |=> error_bank_control ==
         (($past(acc_wdata) & CONTROL_IMPL_MASK) |
         ($past(error_bank_control) & ~CONTROL_IMPL_MASK));
   endproperty
   a_ctl_wr: assert property (p_ctl_wr)
      else $error("control write");
   property p_ctl_keep;
      !$stable(error_bank_control) |-> $past(t_ctl && acc_wr);
   endproperty
   a_ctl_keep: assert property (p_ctl_keep)
      else $error("control moved");
   property p_ctl_rd;
      t_ctl && acc_rd |=> acc_ack && acc_rdata == error_bank_control
         ##1 !acc_ack;
   endproperty
   a_ctl_rd: assert property (p_ctl_rd)
      else $error("control read");
   property p_fault;
      acc_gp_fault |-> acc_ack && acc_rdata == 64'h0;
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault with data");
endmodule

bind ebsl_logger ebsl_chk #(
   .LOCATION_PRESENT(LOCATION_PRESENT),
   .CONTROL_IMPL_MASK(CONTROL_IMPL_MASK)
) u_chk (
   .clk(clk), .reset_n(reset_n), .event_valid(event_valid),
   .event_info(event_info), .extra_info_present(extra_info_present),
   .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_sel(acc_sel),
   .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_gp_fault(acc_gp_fault),
   .acc_rdata(acc_rdata), .error_bank_control(error_bank_control),
   .bank_overflow(bank_overflow)
);
`default_nettype wire

// file: dv/tb_ebsl_logger.sv
// error bank status logger: self-checking bench for the top module
// assumes: package, header and design files compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ebsl_regs.svh"
module tb_ebsl_logger;
   import ebsl_pkg::*;
   // ---------------------------------------------------------------
   // signals and tables
   // ---------------------------------------------------------------
   typedef struct {
      int a;
      int b;
      int w;
   } ebsl_row_s;
   localparam logic [1:0] S_CTL = `EBSL_SEL_CONTROL;
   localparam logic [1:0] S_ST = `EBSL_SEL_STATUS;
   localparam logic [1:0] S_LOC = `EBSL_SEL_LOCATION;
   localparam logic [63:0] CTL_V = 64'hF0F0000000000005;
   logic clk;
   logic reset_n;
   logic event_valid;
   logic extra_info_present;
   logic acc_rd;
   logic acc_wr;
   logic acc_ack;
   logic acc_gp_fault;
   logic bank_overflow;
   logic flt;
   logic [1:0] acc_sel;
   logic [63:0] acc_wdata;
   logic [63:0] acc_rdata;
   logic [63:0] error_bank_control;
   logic [63:0] rd;
   ebsl_event_s event_info;
   ebsl_event_s ev_t [7];
   int n_fail = 0;
   int n_checks = 0;
   // first event (-1 none), second event, expected survivor
   ebsl_row_s rows [15] = '{'{-1, 0, 0}, '{-1, 1, 1}, '{-1, 3, 3}, '{-1, 4, 4},
      '{-1, 6, 6}, '{0, 1, 1}, '{1, 2, 2}, '{2, 1, 2}, '{0, 3, 3}, '{3, 2, 3},
      '{3, 5, 3}, '{4, 0, 0}, '{0, 4, 0}, '{6, 2, 2}, '{-1, 2, 2}};

   ebsl_logger dut (
      .clk(clk), .reset_n(reset_n), .event_valid(event_valid),
      .event_info(event_info), .extra_info_present(extra_info_present),
      .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_sel(acc_sel),
      .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_gp_fault(acc_gp_fault),
      .acc_rdata(acc_rdata), .error_bank_control(error_bank_control),
      .bank_overflow(bank_overflow)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // event from flags {not corrected, monitored, above}, enable, code
   function automatic ebsl_event_s mk(logic [2:0] f, logic [5:0] idx,
         logic [15:0] c);
      return '{c, ~c, {5'h0, c} ^ 21'h1ABCD, 4'hA, c[0], c[1], c[2], f[2],
         f[1], f[0], idx, EBSL_LOC_PHYS, {c, ~c, c, 16'h0123}};
   endfunction

   // status word a logged event should leave
   function automatic logic [63:0] xs(ebsl_event_s e, logic ov, logic xp);
      logic [1:0] thr;
      thr = (e.not_corrected | !e.monitored) ? 2'h0 :
         (e.above_threshold ? 2'h2 : 2'h1);
      return {1'b1, ov, e.not_corrected, CTL_V[e.enable_index],
         e.has_extra & xp, e.has_location, e.context_corrupt, 2'h0, thr,
         e.other_info, e.impl_code, e.arch_code};
   endfunction

   // word compare
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one register access, answer captured in rd and flt
   task automatic acc(input logic wr, input logic [1:0] sel,
         input logic [63:0] wd);
      acc_rd = !wr;
      acc_wr = wr;
      acc_sel = sel;
      acc_wdata = wd;
      @(posedge clk);
      #1;
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      if (acc_ack !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED at %0t: no answer", $time);
      end
      rd = acc_rdata;
      flt = acc_gp_fault;
      @(posedge clk);
      #1;
   endtask

   // raise an event for one edge; caller lowers the strobe
   task automatic ev(input ebsl_event_s e);
      event_valid = 1'b1;
      event_info = e;
      @(posedge clk);
      #1;
   endtask

   task automatic wrap_up;
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog, sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // cut a hang well past the expected under two hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      wrap_up();
   end

   initial begin
      int w;
      reset_n = 1'b0;
      event_valid = 1'b0;
      event_info = '0;
      extra_info_present = 1'b0;
      acc_rd = 1'b0;
      acc_wr = 1'b0;
      acc_sel = 2'h0;
      acc_wdata = 64'h0;
      ev_t[0] = mk(3'h0, 6'h0, 16'h1101);
      ev_t[1] = mk(3'h2, 6'h2, 16'h2202);
      ev_t[2] = mk(3'h3, 6'h0, 16'h3307);
      ev_t[3] = mk(3'h7, 6'h0, 16'h4405);
      ev_t[4] = mk(3'h0, 6'h1, 16'h5506);
      ev_t[5] = mk(3'h4, 6'h2, 16'h6603);
      ev_t[6] = mk(3'h4, 6'h1, 16'h8804);
      repeat (20) @(posedge clk);
      #1;
      reset_n = 1'b1;
      acc(1'b1, S_CTL, CTL_V);
      acc(1'b0, S_CTL, 64'h0);
      chk(rd, CTL_V);
      chk(error_bank_control, CTL_V);
      // logging and collision table
      foreach (rows[i]) begin
         w = rows[i].w;
         extra_info_present = i[0];
         acc(1'b1, S_ST, 64'h0);
         if (rows[i].a >= 0) begin
            ev(ev_t[rows[i].a]);
         end
         ev(ev_t[rows[i].b]);
         event_valid = 1'b0;
         acc(1'b0, S_ST, 64'h0);
         chk(rd, xs(ev_t[w], rows[i].a >= 0, i[0]));
         chk({63'h0, bank_overflow}, {63'h0, rows[i].a >= 0});
         acc(1'b0, S_LOC, 64'h0);
         chk(rd, ev_t[w].has_location ? ev_t[w].location : 64'h0);
      end
      // refused writes fault and leave status alone; a zero write clears location
      acc(1'b1, S_ST, 64'h1);
      chk({63'h0, flt}, 64'h1);
      acc(1'b0, S_ST, 64'h0);
      chk(rd, xs(ev_t[2], 1'b0, 1'b0));
      acc(1'b1, S_LOC, 64'hFF);
      chk({63'h0, flt}, 64'h1);
      acc(1'b1, S_LOC, 64'h0);
      chk({63'h0, flt}, 64'h0);
      acc(1'b0, S_LOC, 64'h0);
      chk(rd, 64'h0);
      // extra info word is not held here, so any access faults
      acc(1'b0, 2'h3, 64'h0);
      chk({63'h0, flt}, 64'h1);
      // clear racing an event: the event is kept
      acc(1'b1, S_ST, 64'h0);
      event_valid = 1'b1;
      event_info = ev_t[0];
      fork
         acc(1'b1, S_ST, 64'h0);
         begin
            @(posedge clk);
            #1;
            event_valid = 1'b0;
         end
      join
      acc(1'b0, S_ST, 64'h0);
      chk(rd, xs(ev_t[0], 1'b0, 1'b0));
      // reset in mid-run empties every register
      reset_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      reset_n = 1'b1;
      for (int s = 0; s < 3; s++) begin
         acc(1'b0, s[1:0], 64'h0);
         chk(rd, 64'h0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
